// File: hdl/port_mode_regs.svh
// Offsets, field positions and timing counts for the port mode and strap logic
`ifndef PORT_MODE_REGS_SVH
`define PORT_MODE_REGS_SVH
`define ADDR_WIDTH      5
`define CTRL_ISOLATE    10
`define CTRL_SPEED      13
`define RX_FLOAT_COUNT  7
`define SYS_PERIOD_NS   8
`define LED_HOLD_NS     40000
`define LED_HOLD_CYCLES ((`LED_HOLD_NS) / (`SYS_PERIOD_NS))
`endif

// File: hdl/port_mode_pkg.sv
// Types shared by the port mode and strap logic
`default_nettype none
package port_mode_pkg;
  typedef enum logic [4:0] {
    MODE_MII10    = 5'h01,
    MODE_MII100   = 5'h02,
    MODE_SYMBOL   = 5'h04,
    MODE_SERIAL10 = 5'h08,
    MODE_PULSE    = 5'h10
  } port_mode_type;

  // Strap pins that pick the interface configuration
  typedef struct packed {
    logic strap_or_register_control_select;
    logic family_select;
    logic serial_or_pulse_select;
    logic speed_select;
    logic node_repeater_select;
    logic duplex_select;
    logic autoneg_select;
  } strap_type;

  // Receive side MII pins toward the MAC
  typedef struct packed {
    logic       rx_clk;
    logic [3:0] rxd;
    logic       rx_err;
    logic       rx_dv;
  } rx_pins_type;

  // Activity sources for the five LEDs
  typedef struct packed {
    logic activity;
    logic collision;
    logic integrity;
    logic transmit;
    logic receive;
  } led_src_type;
endpackage : port_mode_pkg
`default_nettype wire

// File: hdl/port_mode_strap.sv
// Interface mode decode, MII pin remap, strap capture and receive float
`default_nettype none
`include "port_mode_regs.svh"

module port_mode_strap
  import port_mode_pkg::*;
#(
  parameter int LED_HOLD = `LED_HOLD_CYCLES
)(
  // System clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // Configuration straps and control bits
  input  wire port_mode_pkg::strap_type    straps,
  input  wire logic [15:0]                 control_reg,
  input  wire logic                        rx_path_float,
  output logic [4:0]                       mode_onehot,
  output logic                             pulse_mode,
  output logic                             repeater_mode,
  output logic                             speed_100,
  output logic                             full_duplex,
  output logic                             autoneg_enable,
  output logic                             tx_isolate,
  // Receive path from the core and toward the pins
  input  wire port_mode_pkg::rx_pins_type  rx_core,
  output port_mode_pkg::rx_pins_type       rx_pin_o,
  output logic [6:0]                       rx_pin_oe,
  // Link pulse side, clocked by the pulse transmit clock except link_state_out, which is registered on clk_sys
  input  wire logic                        pulse_tx_clock,
  input  wire logic                        pulse_tx_request,
  input  wire logic                        signal_detect,
  output logic                             link_state_out,
  output logic                             nlp_send,
  input  wire logic                        nlp_seen,
  output logic                             pulse_rx_indicate,
  // Status toward the pins and the management block
  input  wire logic                        link_up,
  input  wire logic                        cipher_locked,
  output logic                             lock_out,
  output logic [`ADDR_WIDTH-1:0]           phy_address,
  output logic [15:0]                      quick_status,
  // Shared LED and address pins
  input  wire port_mode_pkg::led_src_type  led_src,
  input  wire logic [4:0]                  led_pin_i,
  output logic [4:0]                       led_pin_o,
  output logic [4:0]                       led_pin_oe
);
  import port_mode_pkg::*;

  // Decode one of the five configurations from the straps
  function automatic port_mode_type decode_mode(input strap_type s, input logic sw_speed);
    logic spd;
    spd = s.strap_or_register_control_select ? sw_speed : s.speed_select;
    if (!s.family_select)
      decode_mode = spd ? MODE_MII100 : MODE_MII10;
    else if (!s.serial_or_pulse_select)
      decode_mode = spd ? MODE_SYMBOL : MODE_SERIAL10;
    else if (!s.strap_or_register_control_select && s.speed_select)
      decode_mode = MODE_PULSE;
    else
      decode_mode = MODE_SERIAL10;
  endfunction : decode_mode

  // Straps come from pins, so two stages before use
  strap_type strap_s1_q;
  strap_type strap_s2_q;
  logic      float_s1_q;
  logic      float_s2_q;
  always_ff @(posedge clk_sys)
  begin
    strap_s1_q <= straps;
    strap_s2_q <= strap_s1_q;
    float_s1_q <= rx_path_float;
    float_s2_q <= float_s1_q;
  end

  port_mode_type mode_q;
  port_mode_type mode_d;
  assign mode_d = decode_mode(strap_s2_q, control_reg[`CTRL_SPEED]);

  // Registered mode; no partial pulse-mode entry is possible
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      mode_q <= MODE_MII10;
    else
      mode_q <= mode_d;
  end

  // Strap settings; the register overrides speed only in software mode, and isolate comes from the register in every mode
  logic sw_mode;
  assign sw_mode        = strap_s2_q.strap_or_register_control_select;
  assign mode_onehot    = mode_q;
  assign pulse_mode     = (mode_q == MODE_PULSE);
  assign repeater_mode  = strap_s2_q.node_repeater_select;
  assign speed_100      = sw_mode ? control_reg[`CTRL_SPEED] : strap_s2_q.speed_select;
  assign full_duplex    = strap_s2_q.duplex_select;
  assign autoneg_enable = strap_s2_q.autoneg_select & ~pulse_mode;
  assign tx_isolate     = control_reg[`CTRL_ISOLATE];

  // Receive float: pin or isolate, in any configuration
  logic rx_float;
  assign rx_float = float_s2_q | control_reg[`CTRL_ISOLATE];

  // Receive outputs registered; pulse mode parks data lines low
  rx_pins_type rx_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rx_q <= '0;
    else if (pulse_mode)
    begin
      rx_q.rx_clk <= rx_core.rx_clk;
      rx_q.rxd    <= 4'h0;
      rx_q.rx_dv  <= 1'b0;
      rx_q.rx_err <= 1'b0;
    end
    else
      rx_q <= rx_core;
  end

  // Pulse indication is driven on the receive error pin from the link domain
  always_comb
  begin
    rx_pin_o = rx_q;
    if (pulse_mode)
      rx_pin_o.rx_err = pulse_rx_indicate;
  end
  assign rx_pin_oe = rx_float ? 7'h00 : 7'h7F;

  // Mode level into the link domain
  logic pmode_l1_q;
  logic pmode_l2_q;
  logic req_l1_q;
  logic req_l2_q;
  logic sd_l1_q;
  logic sd_l2_q;
  logic seen_l1_q;
  logic seen_l2_q;
  logic seen_l3_q;
  always_ff @(posedge pulse_tx_clock)
  begin
    pmode_l1_q <= pulse_mode;
    pmode_l2_q <= pmode_l1_q;
    req_l1_q   <= pulse_tx_request;
    req_l2_q   <= req_l1_q;
    sd_l1_q    <= signal_detect;
    sd_l2_q    <= sd_l1_q;
    seen_l1_q  <= nlp_seen;
    seen_l2_q  <= seen_l1_q;
    seen_l3_q  <= seen_l2_q;
  end

  // One pulse per request edge, one clock period long; pulse mode needs the speed strap high
  logic send_q;
  logic rxind_q;
  logic prev_req_q;
  always_ff @(posedge pulse_tx_clock)
  begin
    prev_req_q <= req_l2_q;
    send_q     <= pmode_l2_q & req_l2_q & ~prev_req_q;
    rxind_q    <= pmode_l2_q & seen_l2_q & ~seen_l3_q;
  end
  assign nlp_send          = send_q;
  assign pulse_rx_indicate = rxind_q;

  // Status pin: signal detect in pulse mode, link state otherwise
  logic sd_sys;
  logic link_state_out_q;
  logic lock_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      link_state_out_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      link_state_out_q <= pulse_mode ? sd_sys : link_up;
      lock_q <= cipher_locked;
    end
  end
  assign link_state_out = link_state_out_q;
  assign lock_out       = lock_q;

  // Signal detect back into the system domain for the status pin
  logic sd_s1_q;
  logic sd_s2_q;
  always_ff @(posedge clk_sys)
  begin
    sd_s1_q <= sd_l2_q;
    sd_s2_q <= sd_s1_q;
  end
  assign sd_sys = sd_s2_q;

  // Address straps: two stages, captured on the cycle reset falls
  logic [4:0] addr_s1_q;
  logic [4:0] addr_s2_q;
  logic [4:0] addr_q;
  logic       was_reset_q;
  always_ff @(posedge clk_sys)
  begin
    addr_s1_q <= led_pin_i;
    addr_s2_q <= addr_s1_q;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      was_reset_q <= 1'b1;
    else
      was_reset_q <= 1'b0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset && was_reset_q)
      addr_q <= addr_s2_q;
  end
  assign phy_address = addr_q;

  // LED drive: pins float in reset, then the strap sets the lit level
  logic [4:0] led_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset || was_reset_q)
      led_q <= 5'h00;
    else
      led_q <= {led_src.receive, led_src.transmit, led_src.integrity,
                led_src.collision, led_src.activity};
  end
  // A pin strapped high idles high, so the LED lights when pulled low
  assign led_pin_o  = led_q ^ addr_q;
  assign led_pin_oe = (reset || was_reset_q) ? 5'h00 : 5'h1F;

  // One-word status snapshot for a single management read
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      quick_status <= 16'h0000;
    else
      quick_status <= {6'h00, mode_q, lock_q, link_state_out_q, full_duplex, speed_100,
                       autoneg_enable};
  end

  // Management pins are outside this block; it never gates them by mode

  // Pulse mode never taken without the hardware strap pattern
  pulse_entry_a: assert property (@(posedge clk_sys) disable iff (reset)
    pulse_mode |-> $past(!strap_s2_q.strap_or_register_control_select &&
      strap_s2_q.family_select && strap_s2_q.serial_or_pulse_select &&
      strap_s2_q.speed_select))
    else $error("pulse mode without strap pattern");
  rx_float_a: assert property (@(posedge clk_sys) disable iff (reset)
    rx_float |-> rx_pin_oe == 7'h00)
    else $error("receive path driven while floated");
  isolate_a: assert property (@(posedge clk_sys) disable iff (reset)
    control_reg[`CTRL_ISOLATE] |-> tx_isolate && rx_pin_oe == 7'h00)
    else $error("isolate not applied");
  pulse_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    pulse_mode && $past(pulse_mode) |=> rx_q.rxd == 4'h0 && !rx_q.rx_dv)
    else $error("data lines active in pulse mode");
  led_input_a: assert property (@(posedge clk_sys)
    reset |-> led_pin_oe == 5'h00)
    else $error("led pins driven in reset");
  addr_cap_a: assert property (@(posedge clk_sys)
    $fell(reset) |=> phy_address == $past(addr_s2_q))
    else $error("address not captured");
  tx_pulse_a: assert property (@(posedge pulse_tx_clock)
    send_q |=> !send_q)
    else $error("pulse request longer than one period");
  rx_pulse_a: assert property (@(posedge pulse_tx_clock)
    rxind_q |=> !rxind_q)
    else $error("pulse indication longer than one period");

  // Link-domain steps of a transmit pulse request
  sequence req_edge_s;
    pmode_l2_q && req_l2_q && !prev_req_q;
  endsequence

  // A single send pulse that drops on the following link edge
  sequence send_one_s;
    send_q ##1 !send_q;
  endsequence

  // Each synced request edge gives exactly one send pulse
  tx_latency_a: assert property (@(posedge pulse_tx_clock)
    req_edge_s |=> send_one_s)
    else $error("send pulse missing after request");

  // Link-domain steps of a detected line pulse
  sequence seen_edge_s;
    pmode_l2_q && seen_l2_q && !seen_l3_q;
  endsequence

  // A single indication that drops on the following link edge
  sequence rxind_one_s;
    rxind_q ##1 !rxind_q;
  endsequence

  // Each synced line pulse gives exactly one receive indication
  rx_latency_a: assert property (@(posedge pulse_tx_clock)
    seen_edge_s |=> rxind_one_s)
    else $error("receive indication missing after line pulse");

  // Outside pulse mode the link side stays quiet whatever the MAC does
  pulse_refuse_a: assert property (@(posedge pulse_tx_clock)
    !pmode_l2_q |=> !send_q && !rxind_q)
    else $error("pulse activity outside pulse mode");

  // Exactly one configuration is active at any time
  mode_single_a: assert property (@(posedge clk_sys) disable iff (reset)
    $onehot(mode_onehot))
    else $error("mode not one-hot");

  // The MAC owns negotiation in pulse mode, so local negotiation is off
  pulse_noneg_a: assert property (@(posedge clk_sys) disable iff (reset)
    pulse_mode |-> !autoneg_enable)
    else $error("local negotiation on in pulse mode");

  // Status pin follows link state one cycle later outside pulse mode
  link_state_out_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    !pulse_mode |=> link_state_out == $past(link_up))
    else $error("link status pin not following link state");

  // Lock pin follows the cipher lock one cycle later
  lock_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> lock_out == $past(cipher_locked))
    else $error("lock pin not following cipher lock");

  // Once reset is well over, every shared pin drives its LED
  led_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
    !was_reset_q |-> led_pin_oe == 5'h1F)
    else $error("led pins not driven after reset");

  // Error pin carries the pulse indication while in pulse mode
  rx_err_map_a: assert property (@(posedge clk_sys) disable iff (reset)
    pulse_mode |-> rx_pin_o.rx_err == pulse_rx_indicate)
    else $error("pulse indication not on error pin");
endmodule : port_mode_strap
`default_nettype wire

// File: tb/pulse_mac_model.sv
// Behavioural MAC side of the link pulse interface
`default_nettype none
module pulse_mac_model (
  // Link pulse lines
  output logic      pulse_tx_clock,
  output logic      pulse_tx_request,
  output logic      nlp_seen,
  input  wire logic nlp_send,
  input  wire logic pulse_rx_indicate,
  // Bench control
  input  wire logic run
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_seen = 0;
  int rx_seen = 0;

  // Link clock stands still while run is low, odd phase offset
  initial
  begin
    pulse_tx_clock = 1'b0;
    pulse_tx_request = 1'b0;
    nlp_seen = 1'b0;
    #3.1;
    forever
    begin
      #62.5;
      pulse_tx_clock = run ? ~pulse_tx_clock : 1'b0;
    end
  end

  // Count one-period pulses coming back from the device
  always @(posedge pulse_tx_clock)
  begin
    tx_seen <= tx_seen + int'(nlp_send === 1'b1);
    rx_seen <= rx_seen + int'(pulse_rx_indicate === 1'b1);
  end

  // MAC sequences each pulse itself; two periods high, two low
  task automatic send_pulse();
    @(posedge pulse_tx_clock);
    pulse_tx_request <= 1'b1;
    repeat (2) @(posedge pulse_tx_clock);
    pulse_tx_request <= 1'b0;
    repeat (2) @(posedge pulse_tx_clock);
  endtask : send_pulse

  // Pulse detected on the line
  task automatic line_pulse();
    @(posedge pulse_tx_clock);
    nlp_seen <= 1'b1;
    repeat (2) @(posedge pulse_tx_clock);
    nlp_seen <= 1'b0;
    repeat (2) @(posedge pulse_tx_clock);
  endtask : line_pulse
endmodule : pulse_mac_model
`default_nettype wire

// File: tb/port_mode_strap_tb.sv
// Self-checking bench for the port mode and strap logic
`default_nettype none
module port_mode_strap_tb;
  import port_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, rx_path_float, link_up, cipher_locked, signal_detect, run;
  logic        pulse_mode, repeater_mode, speed_100, full_duplex, autoneg_enable, tx_isolate;
  logic        pulse_tx_clock, pulse_tx_request, nlp_send, nlp_seen, pulse_rx_indicate;
  logic        link_state_out, lock_out;
  strap_type   straps;
  rx_pins_type rx_core, rx_pin_o;
  led_src_type led_src;
  logic [15:0] control_reg, quick_status;
  logic [6:0]  rx_pin_oe;
  logic [4:0]  mode_onehot, phy_address, led_pin_i, led_pin_o, led_pin_oe, strap_lvl;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  // Shared pins read the strap resistor unless the device drives them
  assign led_pin_i = (led_pin_oe & led_pin_o) | (~led_pin_oe & strap_lvl);

  port_mode_strap i_dut (.clk_sys, .reset, .straps, .control_reg, .rx_path_float,
    .mode_onehot, .pulse_mode, .repeater_mode, .speed_100, .full_duplex, .autoneg_enable,
    .tx_isolate, .rx_core, .rx_pin_o, .rx_pin_oe, .pulse_tx_clock, .pulse_tx_request,
    .signal_detect, .link_state_out, .nlp_send, .nlp_seen, .pulse_rx_indicate, .link_up,
    .cipher_locked, .lock_out, .phy_address, .quick_status, .led_src, .led_pin_i,
    .led_pin_o, .led_pin_oe);

  pulse_mac_model i_mac (.pulse_tx_clock, .pulse_tx_request, .nlp_seen, .nlp_send,
    .pulse_rx_indicate, .run);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Inputs move on falling edges only
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : settle

  task automatic reset_straps();
    settle(16);
    chk("led oe in reset", 16'h0, {11'h0, led_pin_oe});
    reset = 1'b0;
    settle(8);
    chk("address", 16'h15, {11'h0, phy_address});
    chk("led oe", 16'h1F, {11'h0, led_pin_oe});
    chk("led idle", 16'h15, {11'h0, led_pin_o});
    led_src = '1;
    settle(3);
    chk("led lit", 16'h0A, {11'h0, led_pin_o});
    led_src = '0;
  endtask : reset_straps

  task automatic mode_table();
    logic [6:0] s [7] = '{7'h07, 7'h08, 7'h28, 7'h20, 7'h38, 7'h30, 7'h78};
    logic [4:0] m [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h08, 5'h08};
    logic [3:0] cfg;
    for (int i = 0; i < 7; i++)
    begin
      straps = s[i];
      rx_path_float = 1'b1;
      settle(6);
      cfg = {speed_100, repeater_mode, full_duplex, autoneg_enable};
      chk("mode", {11'h0, m[i]}, {11'h0, mode_onehot});
      chk("pulse mode", {15'h0, m[i] == 5'h10}, {15'h0, pulse_mode});
      chk("rx float", 16'h0, {9'h0, rx_pin_oe});
      if (!s[i][6])
        chk("strap config", {12'h0, s[i][3:0]}, {12'h0, cfg});
      rx_path_float = 1'b0;
      settle(6);
      chk("rx drive", 16'h7F, {9'h0, rx_pin_oe});
    end
  endtask : mode_table

  task automatic isolate();
    control_reg = 16'h0400;
    settle(6);
    chk("isolate rx", 16'h0, {9'h0, rx_pin_oe});
    chk("isolate tx", 16'h1, {15'h0, tx_isolate});
    control_reg = 16'h0;
    settle(6);
    chk("isolate off", 16'h7F, {9'h0, rx_pin_oe});
  endtask : isolate

  // One read word carries mode, lock, link and strap state
  task automatic status();
    straps = 7'h0A;
    link_up = 1'b1;
    settle(6);
    chk("link out", 16'h1, {15'h0, link_state_out});
    chk("status word", 16'h004E, quick_status);
    link_up = 1'b0;
    cipher_locked = 1'b1;
    settle(6);
    chk("lock out", 16'h1, {15'h0, lock_out});
    chk("status word", 16'h0056, quick_status);
  endtask : status

  task automatic pulses();
    straps = 7'h38;
    signal_detect = 1'b1;
    rx_core = '1;
    run = 1'b1;
    settle(100);
    chk("signal detect", 16'h1, {15'h0, link_state_out});
    chk("rx pins pulse", 16'h40, {9'h0, rx_pin_o});
    i_mac.send_pulse();
    i_mac.send_pulse();
    i_mac.line_pulse();
    settle(100);
    chk("tx pulses", 16'h2, i_mac.tx_seen[15:0]);
    chk("rx pulses", 16'h1, i_mac.rx_seen[15:0]);
    straps = 7'h08;
    settle(20);
    chk("link source", 16'h0, {15'h0, link_state_out});
    chk("rx pins mii", 16'h7F, {9'h0, rx_pin_o});
    rx_core = '0;
    i_mac.send_pulse();
    settle(100);
    chk("refused", 16'h2, i_mac.tx_seen[15:0]);
    run = 1'b0;
  endtask : pulses

  initial
  begin
    reset = 1'b1;
    straps = '0;
    control_reg = '0;
    rx_path_float = 1'b0;
    rx_core = '0;
    led_src = '0;
    strap_lvl = 5'h15;
    link_up = 1'b0;
    cipher_locked = 1'b0;
    signal_detect = 1'b0;
    run = 1'b0;
    reset_straps();
    mode_table();
    isolate();
    status();
    pulses();
    finish_test();
  end

  // Hang guard
  initial
  begin
    #500us;
    n_mismatch++;
    finish_test();
  end
endmodule : port_mode_strap_tb
`default_nettype wire
